// ==== shared/flash_host_pkg.sv ====
package flash_host_pkg;

	// Clock and strobe timing, least times rounded up to whole cycles
	localparam int         CLK_NS      = 20;
	localparam int         T_WP_NS     = 35;
	localparam int         T_WPH_NS    = 30;
	localparam int         T_ACC_NS    = 90;
	localparam int         T_RP_NS     = 500;
	localparam int         T_RH_NS     = 50;
	localparam int         SYNC_STAGES = 3;
	localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RH_CYC  = 8'((T_RH_NS + CLK_NS - 1) / CLK_NS);
	// Access time, three sync stages, filter stage and pin register lag;
	// one cycle less samples the filter before the data has settled
	localparam logic [7:0] RD_CYC  =
		8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 2);

	localparam int ADDR_W = 23;

	// Unlock addresses and command bytes
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 23'h000aaa;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 23'h000555;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_ID      = 8'h90;
	localparam logic [7:0] CMD_SEC     = 8'h88;
	localparam logic [7:0] CMD_EXIT    = 8'h00;
	localparam logic [7:0] CMD_PROG    = 8'ha0;
	localparam logic [7:0] CMD_BYPASS  = 8'h20;
	localparam logic [7:0] CMD_ESETUP  = 8'h80;
	localparam logic [7:0] CMD_CHIP    = 8'h10;
	localparam logic [7:0] CMD_RESET   = 8'hf0;

	// Write counts of the sequences
	localparam logic [2:0] LEN_ONE   = 3'd1;
	localparam logic [2:0] LEN_TWO   = 3'd2;
	localparam logic [2:0] LEN_THREE = 3'd3;
	localparam logic [2:0] LEN_FOUR  = 3'd4;
	localparam logic [2:0] LEN_SIX   = 3'd6;

	// Status bits on the flash data lines
	localparam int LIMIT_BIT  = 5;
	localparam int TOGGLE_BIT = 6;

	// Own register map and fields
	localparam logic [5:0] REG_CTRL   = 6'h00;
	localparam logic [5:0] REG_ADDR   = 6'h04;
	localparam logic [5:0] REG_WDATA  = 6'h08;
	localparam logic [5:0] REG_STATUS = 6'h0c;
	localparam int CTRL_ACCEL_BIT = 4;
	localparam int ST_BUSY        = 0;
	localparam int ST_LIMIT       = 1;
	localparam int ST_REFUSED     = 2;
	localparam int ST_RDY         = 3;
	localparam int ST_MODE_LSB    = 4;
	localparam int ST_DATA_LSB    = 8;

	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID_ENTER = 4'h2,
		OP_SEC_ENTER = 4'h3, OP_SEC_EXIT = 4'h4, OP_PROGRAM = 4'h5,
		OP_BYP_ENTER = 4'h6, OP_BYP_PROGRAM = 4'h7, OP_BYP_EXIT = 4'h8,
		OP_CHIP_ERASE = 4'h9, OP_HW_RESET = 4'ha
	} op_t;

	typedef enum logic [1:0] {
		M_READ = 2'h0, M_ID = 2'h1, M_SEC = 2'h2, M_BYP = 2'h3
	} mode_t;

	typedef struct packed {
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic              reset_n;
		logic              accel;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        dq_o;
		logic              dq_oe;
	} flash_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} bus_cycle_t;

	localparam flash_pins_t PINS_RST = '{ce_n: 1'b1, we_n: 1'b1,
		oe_n: 1'b1, reset_n: 1'b1, accel: 1'b0, addr: '0, dq_o: '0,
		dq_oe: 1'b0};
	localparam logic [8:0] SYNC_RST = 9'h100;

endpackage

// ==== verilog/flash_host.sv ====
`timescale 1ns/10ps

module flash_host
	import flash_host_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  dq_i,
	input  wire logic        ready_busy_n,
	output flash_pins_t      pins
);

	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_WR_SET = 4'h1, S_WR_PULSE = 4'h2,
		S_WR_HOLD = 4'h3, S_WR_GAP = 4'h4, S_RD_ACC = 4'h5,
		S_RD_END = 4'h6, S_RST_LOW = 4'h7, S_RST_WAIT = 4'h8
	} state_t;

	state_t            st_q;
	op_t               op_q;
	mode_t             mode_q;
	logic              accel_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0]        wdata_q;
	logic [7:0]        rd_q;
	logic [7:0]        cnt_q;
	logic [2:0]        step_q;
	logic              polling_q;
	logic              prev_ok_q;
	logic              prev_tog_q;
	logic              lim_seen_q;
	logic              limit_q;
	logic              refused_q;
	logic [8:0]        s1_q;
	logic [8:0]        s2_q;
	logic [8:0]        s3_q;
	logic [8:0]        filt_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic [5:0]        aw_q;
	logic [31:0]       w_q;
	logic [3:0]        strb_q;

	// Write count of each command sequence
	function automatic logic [2:0] seq_len(op_t op);
		case (op)
			OP_RESET:                     return LEN_ONE;
			OP_ID_ENTER, OP_SEC_ENTER,
			OP_BYP_ENTER:                 return LEN_THREE;
			OP_SEC_EXIT, OP_PROGRAM:      return LEN_FOUR;
			OP_BYP_PROGRAM, OP_BYP_EXIT:  return LEN_TWO;
			OP_CHIP_ERASE:                return LEN_SIX;
			default:                      return 3'd0;
		endcase
	endfunction

	// Address and data of write i; unlock pairs sit at steps 0,1 and 3,4
	function automatic bus_cycle_t seq_cycle(op_t op, logic [2:0] i,
		logic [ADDR_W-1:0] a, logic [7:0] d);
		bus_cycle_t c;
		logic       second;
		second = (i == 3'd1) || (i == 3'd4);
		c.addr = second ? UNLOCK_A2 : UNLOCK_A1;
		c.data = second ? CMD_UNLOCK2 : CMD_UNLOCK1;
		case (op)
			OP_RESET:     c.data = CMD_RESET;
			OP_ID_ENTER:  if (i == 3'd2) c.data = CMD_ID;
			OP_SEC_ENTER: if (i == 3'd2) c.data = CMD_SEC;
			OP_SEC_EXIT:  if (i == 3'd2) c.data = CMD_ID;
				else if (i == 3'd3) c.data = CMD_EXIT;
			OP_PROGRAM:   if (i == 3'd2) c.data = CMD_PROG;
				else if (i == 3'd3) c = '{addr: a, data: d};
			OP_BYP_ENTER: if (i == 3'd2) c.data = CMD_BYPASS;
			OP_BYP_PROGRAM: if (i == 3'd0) c.data = CMD_PROG;
				else c = '{addr: a, data: d};
			OP_BYP_EXIT:  c.data = (i == 3'd0) ? CMD_ID : CMD_EXIT;
			OP_CHIP_ERASE: if (i == 3'd2) c.data = CMD_ESETUP;
				else if (i == 3'd5) c.data = CMD_CHIP;
			default: ;
		endcase
		return c;
	endfunction

	// Mode the flash is in once the op has finished
	function automatic mode_t next_mode(op_t op, mode_t m);
		case (op)
			OP_ID_ENTER:                       return M_ID;
			OP_SEC_ENTER:                      return M_SEC;
			OP_BYP_ENTER:                      return M_BYP;
			OP_RESET, OP_SEC_EXIT, OP_BYP_EXIT,
			OP_HW_RESET:                       return M_READ;
			default:                           return m;
		endcase
	endfunction

	// Ops the flash would accept in its present mode
	function automatic logic op_allowed(op_t op, mode_t m, logic acc);
		case (m)
			M_BYP: return op inside {OP_READ, OP_BYP_PROGRAM,
				OP_BYP_EXIT};
			M_ID:  return op inside {OP_READ, OP_RESET};
			default: return (op <= OP_HW_RESET) && (op != OP_BYP_EXIT)
				&& (op != OP_BYP_PROGRAM || acc);
		endcase
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] nw, logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// Register decode
	wire        wr_go     = aw_have_q && w_have_q && !s_axi_bvalid;
	wire        idle      = (st_q == S_IDLE);
	wire op_t   new_op    = op_t'(w_q[3:0]);
	wire        new_accel = w_q[CTRL_ACCEL_BIT];
	wire        ctrl_wr   = wr_go && aw_q == REG_CTRL && strb_q[0];
	wire        hw_start  = ctrl_wr && new_op == OP_HW_RESET;
	wire        start_ok  = hw_start || (ctrl_wr && idle
		&& op_allowed(new_op, mode_q, new_accel));
	wire        data_wr   = wr_go && idle
		&& (aw_q == REG_ADDR || aw_q == REG_WDATA);
	wire        busy_wr   = wr_go && !idle
		&& (aw_q == REG_ADDR || aw_q == REG_WDATA);
	wire [31:0] addr_new  = merge({9'h0, addr_q}, w_q, strb_q);
	wire [31:0] wdat_new  = merge({24'h0, wdata_q}, w_q, strb_q);
	wire bus_cycle_t cyc  = seq_cycle(op_q, step_q, addr_q, wdata_q);
	wire        last_step = (step_q + 3'd1) >= seq_len(op_q);
	wire        polled    = op_q inside {OP_PROGRAM, OP_BYP_PROGRAM,
		OP_CHIP_ERASE};
	wire        tog       = rd_q[TOGGLE_BIT];

	logic [31:0] status_w;
	logic [31:0] rd_mux;

	// Status word and read mux
	always_comb
	begin
		status_w = '0;
		status_w[ST_BUSY] = !idle;
		status_w[ST_LIMIT] = limit_q;
		status_w[ST_REFUSED] = refused_q;
		status_w[ST_RDY] = filt_q[8];
		status_w[ST_MODE_LSB +: 2] = mode_q;
		status_w[ST_DATA_LSB +: 8] = rd_q;
		case (s_axi_araddr)
			REG_CTRL:   rd_mux = {27'h0, accel_q, op_q};
			REG_ADDR:   rd_mux = {9'h0, addr_q};
			REG_WDATA:  rd_mux = {24'h0, wdata_q};
			REG_STATUS: rd_mux = status_w;
			default:    rd_mux = '0;
		endcase
	end

	// AXI write side: address and data taken in either order
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_q          <= '0;
			w_q           <= '0;
			strb_q        <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q          <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q          <= s_axi_wdata;
				strb_q       <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
				s_axi_bvalid <= 1'b1;
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				aw_have_q     <= 1'b0;
				w_have_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI read side: data one cycle after the address is taken
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	assign s_axi_bresp = 2'b00;
	assign s_axi_rresp = 2'b00;

	// Pin inputs: a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q   <= SYNC_RST;
			s2_q   <= SYNC_RST;
			s3_q   <= SYNC_RST;
			filt_q <= SYNC_RST;
		end
		else
		begin
			s1_q   <= {ready_busy_n, dq_i};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
		end
	end

	// Software registers; address and data frozen while an op runs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_q    <= '0;
			wdata_q   <= '0;
			refused_q <= 1'b0;
		end
		else
		begin
			if (data_wr && aw_q == REG_ADDR)
				addr_q <= addr_new[ADDR_W-1:0];
			if (data_wr && aw_q == REG_WDATA)
				wdata_q <= wdat_new[7:0];
			if (start_ok)
				refused_q <= 1'b0;
			if ((ctrl_wr && !start_ok) || busy_wr)
				refused_q <= 1'b1;
		end
	end

	// Pins follow the sequencer state one cycle later
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pins <= PINS_RST;
		else
		begin
			pins.ce_n    <= !(st_q inside {S_WR_SET, S_WR_PULSE, S_WR_HOLD,
				S_RD_ACC});
			pins.we_n    <= (st_q != S_WR_PULSE);
			pins.oe_n    <= (st_q != S_RD_ACC);
			pins.dq_oe   <= st_q inside {S_WR_SET, S_WR_PULSE, S_WR_HOLD};
			pins.addr    <= (st_q == S_RD_ACC) ? addr_q : cyc.addr;
			pins.dq_o    <= cyc.data;
			pins.reset_n <= (st_q != S_RST_LOW);
			pins.accel   <= accel_q && op_q == OP_BYP_PROGRAM
				&& !idle;
		end
	end

	// Sequencer: writes, status polling, hardware reset pulse
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q       <= S_IDLE;
			op_q       <= OP_READ;
			mode_q     <= M_READ;
			accel_q    <= 1'b0;
			rd_q       <= '0;
			cnt_q      <= '0;
			step_q     <= '0;
			polling_q  <= 1'b0;
			prev_ok_q  <= 1'b0;
			prev_tog_q <= 1'b0;
			lim_seen_q <= 1'b0;
			limit_q    <= 1'b0;
		end
		else if (start_ok)
		begin
			op_q       <= new_op;
			accel_q    <= new_accel;
			step_q     <= '0;
			polling_q  <= 1'b0;
			prev_ok_q  <= 1'b0;
			lim_seen_q <= 1'b0;
			limit_q    <= 1'b0;
			cnt_q      <= (new_op == OP_HW_RESET) ? RP_CYC - 8'd1
				: RD_CYC - 8'd1;
			st_q       <= (new_op == OP_HW_RESET) ? S_RST_LOW
				: (new_op == OP_READ) ? S_RD_ACC : S_WR_SET;
		end
		else
		begin
			case (st_q)
				S_IDLE: ;
				S_WR_SET:
				begin
					st_q  <= S_WR_PULSE;
					cnt_q <= WP_CYC - 8'd1;
				end
				S_WR_PULSE:
					if (cnt_q != 8'd0)
						cnt_q <= cnt_q - 8'd1;
					else
						st_q <= S_WR_HOLD;
				S_WR_HOLD:
				begin
					st_q  <= S_WR_GAP;
					cnt_q <= WPH_CYC - 8'd1;
				end
				S_WR_GAP:
					if (cnt_q != 8'd0)
						cnt_q <= cnt_q - 8'd1;
					else if (!last_step)
					begin
						step_q <= step_q + 3'd1;
						st_q   <= S_WR_SET;
					end
					else if (polled)
					begin
						polling_q <= 1'b1;
						cnt_q     <= RD_CYC - 8'd1;
						st_q      <= S_RD_ACC;
					end
					else
					begin
						st_q   <= S_IDLE;
						mode_q <= next_mode(op_q, mode_q);
					end
				S_RD_ACC:
					if (cnt_q != 8'd0)
						cnt_q <= cnt_q - 8'd1;
					else
					begin
						rd_q <= filt_q[7:0];
						st_q <= S_RD_END;
					end
				S_RD_END:
					if (!polling_q || (prev_ok_q && tog == prev_tog_q))
					begin
						st_q      <= S_IDLE;
						polling_q <= 1'b0;
						mode_q    <= next_mode(op_q, mode_q);
					end
					else if (prev_ok_q && lim_seen_q)
					begin
						limit_q   <= 1'b1;
						op_q      <= OP_RESET;
						step_q    <= '0;
						polling_q <= 1'b0;
						st_q      <= S_WR_SET;
					end
					else
					begin
						lim_seen_q <= rd_q[LIMIT_BIT];
						prev_tog_q <= tog;
						prev_ok_q  <= 1'b1;
						cnt_q      <= RD_CYC - 8'd1;
						st_q       <= S_RD_ACC;
					end
				S_RST_LOW:
					if (cnt_q != 8'd0)
						cnt_q <= cnt_q - 8'd1;
					else
					begin
						cnt_q <= RH_CYC - 8'd1;
						st_q  <= S_RST_WAIT;
					end
				S_RST_WAIT:
					if (cnt_q != 8'd0)
						cnt_q <= cnt_q - 8'd1;
					else
					begin
						st_q   <= S_IDLE;
						mode_q <= M_READ;
					end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	chk_we_in_ce: assert property (@(posedge clk) disable iff (!rstn)
		!pins.we_n |-> !pins.ce_n)
		else $error("write strobe outside chip enable");
	chk_strobe_stable: assert property (
		@(posedge clk) disable iff (!rstn)
		$rose(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_o)
			&& pins.dq_oe)
		else $error("address or data moved under write strobe");
	chk_accel_use: assert property (@(posedge clk) disable iff (!rstn)
		pins.accel |-> op_q == OP_BYP_PROGRAM && mode_q != M_ID)
		else $error("accel pin driven outside bypass program");
	chk_limit_reset: assert property (@(posedge clk) disable iff (!rstn)
		$rose(limit_q) |-> ##[1:4] (!pins.we_n && pins.dq_o == CMD_RESET))
		else $error("no reset write after exceeded limit");
	chk_prog_len: assert property (@(posedge clk) disable iff (!rstn)
		$rose(polling_q) && op_q == OP_PROGRAM |-> step_q == LEN_FOUR - 3'd1)
		else $error("program sequence not four writes");
	chk_byp_len: assert property (@(posedge clk) disable iff (!rstn)
		$rose(polling_q) && op_q == OP_BYP_PROGRAM |-> step_q == 3'd1)
		else $error("bypass program not two writes");
	chk_chip_len: assert property (@(posedge clk) disable iff (!rstn)
		$rose(polling_q) && op_q == OP_CHIP_ERASE |-> step_q == 3'd5)
		else $error("chip erase not six writes");
	chk_bypass_gate: assert property (@(posedge clk) disable iff (!rstn)
		start_ok && !hw_start && mode_q == M_BYP |->
			new_op inside {OP_READ, OP_BYP_PROGRAM, OP_BYP_EXIT})
		else $error("illegal op started in bypass mode");
	chk_id_leave: assert property (@(posedge clk) disable iff (!rstn)
		$past(mode_q) == M_ID && mode_q != M_ID |->
			$past(op_q) inside {OP_RESET, OP_HW_RESET})
		else $error("identifier mode left without reset");
	chk_id_entry: assert property (@(posedge clk) disable iff (!rstn)
		mode_q == M_ID && $past(mode_q) != M_ID |->
			$past(op_q) == OP_ID_ENTER)
		else $error("identifier mode entered wrongly");
	chk_quiet_busy: assert property (@(posedge clk) disable iff (!rstn)
		polling_q |=> !pins.dq_oe && pins.we_n)
		else $error("command driven during embedded operation");
	chk_reset_pulse: assert property (@(posedge clk) disable iff (!rstn)
		$fell(pins.reset_n) |-> !pins.reset_n [*8])
		else $error("hardware reset pulse too short");

endmodule

// ==== tb/flash_model.sv ====
`timescale 1ns/10ps
// Behavioural flash device seen through the controller's pins
module flash_model
	import flash_host_pkg::*;
#(
	parameter int         BUSY_NS = 2000,
	parameter logic [7:0] MAKER   = 8'h3e, // Arbitrary value
	parameter logic [7:0] PART    = 8'hc5  // Arbitrary value
)
(
	input  wire flash_pins_t pins,
	input  wire logic        fail,
	output logic [7:0]       dq_i,
	output logic             ready_busy_n
);
	logic [7:0] mem [256];
	logic [7:0] wa, pa, pd, d, last;
	logic [2:0] st;
	logic       busy, erase, tog;
	int         gen;
	mode_t      mode;
	wire        wr_sel = !pins.ce_n && !pins.we_n;
	wire        rd_en  = !pins.ce_n && !pins.oe_n && pins.reset_n;
	wire        rd_late;
	wire [7:0]  id_val = pins.addr[1] ? 8'h00 : pins.addr[0] ? PART : MAKER;
	wire [7:0]  rd_val;

	// Data only after the access time, else the inverse of the last value
	assign #(T_ACC_NS) rd_late = rd_en;
	assign rd_val = busy ? {1'b0, tog, fail, 2'b00, erase & tog, 2'b00}
		: mode == M_ID ? id_val
		: mode == M_SEC ? 8'h5a ^ {4'h0, pins.addr[3:0]}
		: mem[pins.addr[7:0]];
	assign dq_i = pins.dq_oe ? pins.dq_o : rd_en && rd_late ? rd_val : ~last;
	assign ready_busy_n = !busy;

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'(i) ^ 8'h3c;
		busy = 1'b0;
		tog = 1'b0;
		st = 3'd0;
		gen = 0;
		last = 8'h00;
		mode = M_READ;
	end

	// A stale timer from an aborted op must not finish a newer one
	task automatic run_op(input int g);
		#(BUSY_NS);
		if (busy && g == gen && !fail)
		begin
			if (erase)
				foreach (mem[i])
					mem[i] = 8'hff;
			else
				mem[pa] = mem[pa] & pd;
			busy = 1'b0;
		end
	endtask

	task automatic start(input logic e);
		busy = 1'b1;
		erase = e;
		gen++;
		fork
			run_op(gen);
		join_none
	endtask

	task prog_go;
		pa = wa;
		pd = d;
		st = 3'd0;
		start(1'b0);
	endtask

	task std_step;
		case (st)
			3'd0: st = d == CMD_UNLOCK1 ? 3'd1 : 3'd0;
			3'd1: st = d == CMD_UNLOCK2 ? 3'd2 : 3'd0;
			3'd2:
			begin
				st = d == CMD_PROG ? 3'd4 : d == CMD_ESETUP ? 3'd5
					: d == CMD_ID && mode == M_SEC ? 3'd3 : 3'd0;
				if (d == CMD_ID && mode != M_SEC)
					mode = M_ID;
				if (d == CMD_SEC)
					mode = M_SEC;
				if (d == CMD_BYPASS)
					mode = M_BYP;
			end
			3'd3:
			begin
				mode = d == CMD_EXIT ? M_READ : mode;
				st = 3'd0;
			end
			3'd4: prog_go();
			3'd5: st = d == CMD_UNLOCK1 ? 3'd6 : 3'd0;
			3'd6: st = d == CMD_UNLOCK2 ? 3'd7 : 3'd0;
			default:
			begin
				if (d == CMD_CHIP)
					start(1'b1);
				st = 3'd0;
			end
		endcase
	endtask

	task byp_step;
		case (st)
			3'd0: st = d == CMD_PROG ? 3'd1 : d == CMD_ID ? 3'd2 : 3'd0;
			3'd1: prog_go();
			default:
			begin
				if (d == CMD_EXIT && !pins.accel)
					mode = M_READ;
				st = 3'd0;
			end
		endcase
	endtask

	// Address on the later strobe fall, data on the earlier rise
	always @(posedge wr_sel)
		wa = pins.addr[7:0];
	always @(negedge wr_sel)
	begin
		d = pins.dq_o;
		if (busy && fail && d == CMD_RESET)
			busy = 1'b0;
		else if (busy)
			st = 3'd0;
		else if (d == CMD_RESET && mode != M_BYP)
		begin
			st = 3'd0;
			mode = M_READ;
		end
		else if (mode == M_BYP)
			byp_step();
		else if (mode != M_ID)
			std_step();
	end

	// High voltage forces bypass for as long as it is applied
	always @(posedge pins.accel)
		mode = M_BYP;
	always @(negedge pins.accel)
		mode = M_READ;
	always @(negedge pins.reset_n)
	begin
		busy = 1'b0;
		st = 3'd0;
		mode = M_READ;
	end
	always @(negedge rd_en)
	begin
		last = rd_val;
		tog = busy ? ~tog : tog;
	end
endmodule

// ==== tb/flash_host_tb.sv ====
`timescale 1ns/10ps
module flash_host_tb;
	import flash_host_pkg::*;
	localparam logic [7:0]  MAKER_CODE = 8'h3e; // Arbitrary value
	localparam logic [7:0]  PART_CODE  = 8'hc5; // Arbitrary value
	localparam logic [31:0] M_DATA     = 32'h0000ff00;
	localparam logic [31:0] M_MODE     = 32'h00000030;
	logic        clk, rstn, fail, ready_busy_n;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, lfsr;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  dq_i, img [256];
	flash_pins_t pins;
	logic [31:0] exp_q [$], msk_q [$];
	logic [1:0]  rsp_q [$];
	int          error_cnt, check_count;

	flash_host u_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.dq_i(dq_i), .ready_busy_n(ready_busy_n), .pins(pins));
	flash_model #(.MAKER(MAKER_CODE), .PART(PART_CODE)) u_flash (
		.pins(pins), .fail(fail), .dq_i(dq_i), .ready_busy_n(ready_busy_n));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// A zero mask marks a poll read that is not judged
	task automatic compare(input logic [31:0] m, input logic [31:0] e);
		if (m != 32'h0)
		begin
			check_count++;
			if ((s_axi_rdata & m) !== e)
			begin
				error_cnt++;
				$display("mismatch rdata exp %h got %h", e, s_axi_rdata & m);
			end
		end
	endtask

	// Every write or read answer must carry the noted response code
	task automatic compare_resp(input logic [1:0] e);
		logic [1:0] r;
		r = s_axi_bvalid ? s_axi_bresp : s_axi_rresp;
		check_count++;
		if (r !== e)
		begin
			error_cnt++;
			$display("mismatch resp exp %h got %h", e, r);
		end
	endtask

	// Oldest expectation is matched against each answer
	always @(posedge clk)
	begin
		if (s_axi_rvalid && s_axi_rready && msk_q.size() > 0)
			compare(msk_q.pop_front(), exp_q.pop_front());
		if (((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
			&& rsp_q.size() > 0)
			compare_resp(rsp_q.pop_front());
	end

	// Extra edge at the end keeps a strobe from being set twice at once
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		rsp_q.push_back(2'b00);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge clk);
			if (!aw && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (!w && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			aw = aw || s_axi_awready;
			w = w || s_axi_wready;
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rsp_q.push_back(2'b00);
		msk_q.push_back(m);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		rd_val = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_st(input logic [31:0] m, input logic [31:0] e);
		axi_rd(REG_STATUS, m, e);
	endtask

	task automatic wait_idle;
		do axi_rd(REG_STATUS, 32'h0, 32'h0); while (rd_val[ST_BUSY] !== 1'b0);
	endtask

	task automatic op(input logic [31:0] c);
		axi_wr(REG_CTRL, c);
		wait_idle();
	endtask

	task automatic chk_val(input logic [22:0] a, input logic [7:0] e);
		axi_wr(REG_ADDR, {9'h0, a});
		op(OP_READ);
		rd_st(M_DATA, {16'h0, e, 8'h00});
	endtask

	task automatic chk_byte(input logic [7:0] a);
		chk_val({15'h0, a}, img[a]);
	endtask

	task automatic set_op(input logic [7:0] a, input logic [7:0] d,
		input logic [31:0] c);
		axi_wr(REG_ADDR, {24'h0, a});
		axi_wr(REG_WDATA, {24'h0, d});
		axi_wr(REG_CTRL, c);
	endtask

	// Expected array keeps only the cleared bits
	task automatic pgm_chk(input logic [7:0] a, input logic [7:0] d,
		input logic [31:0] c);
		set_op(a, d, c);
		wait_idle();
		img[a] = img[a] & d;
		chk_byte(a);
	endtask

	// Run-time limit well above the whole sequence
	initial
	begin
		#2000000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		rstn = 1'b0;
		fail = 1'b0;
		lfsr = 32'h1162ac84;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
		s_axi_wstrb = 4'hf;
		error_cnt = 0;
		check_count = 0;
		foreach (img[i])
			img[i] = 8'(i) ^ 8'h3c;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd_st(32'h3f, 32'h08);
		axi_rd(6'h10, 32'hffffffff, 32'h0);
		chk_byte(8'h47);
		s_axi_wstrb <= 4'h1;
		axi_wr(REG_ADDR, 32'h00ffff55);
		s_axi_wstrb <= 4'hf;
		axi_rd(REG_ADDR, 32'hffffffff, 32'h00000055);
		for (int i = 0; i < 2; i++)
		begin
			lfsr = next_rand(lfsr);
			pgm_chk(lfsr[7:0], lfsr[15:8], OP_PROGRAM);
		end
		pgm_chk(lfsr[7:0], 8'hff, OP_PROGRAM);
		op(OP_ID_ENTER);
		rd_st(M_MODE, 32'h10);
		chk_val(23'h0, MAKER_CODE);
		chk_val(23'h1, PART_CODE);
		chk_val(23'h3, 8'h00);
		chk_val(23'h010002, 8'h00);
		axi_wr(REG_CTRL, OP_PROGRAM);
		rd_st(32'h5, 32'h4);
		op(OP_RESET);
		rd_st(32'h34, 32'h0);
		chk_byte(8'h47);
		op(OP_SEC_ENTER);
		rd_st(M_MODE, 32'h20);
		for (int i = 0; i < 16; i++)
			chk_val(23'(i), 8'h5a ^ 8'(i));
		op(OP_SEC_EXIT);
		rd_st(M_MODE, 32'h0);
		chk_byte(8'h47);
		op(OP_BYP_ENTER);
		rd_st(M_MODE, 32'h30);
		lfsr = next_rand(lfsr);
		pgm_chk(lfsr[7:0], lfsr[15:8], OP_BYP_PROGRAM);
		axi_wr(REG_CTRL, OP_ID_ENTER);
		rd_st(32'h34, 32'h34);
		op(OP_BYP_EXIT);
		rd_st(M_MODE, 32'h0);
		lfsr = next_rand(lfsr);
		pgm_chk(lfsr[7:0], lfsr[15:8], 32'h10 | OP_BYP_PROGRAM);
		op(OP_BYP_EXIT);
		rd_st(32'h34, 32'h04);
		axi_wr(REG_CTRL, OP_CHIP_ERASE);
		axi_wr(REG_CTRL, OP_SEC_ENTER);
		rd_st(32'h5, 32'h5);
		wait_idle();
		rd_st(M_MODE, 32'h0);
		foreach (img[i])
			img[i] = 8'hff;
		chk_byte(lfsr[7:0]);
		fail <= 1'b1;
		set_op(8'h21, 8'h00, OP_PROGRAM);
		wait_idle();
		rd_st(32'h33, 32'h02);
		fail <= 1'b0;
		chk_byte(8'h21);
		set_op(8'h21, 8'h00, OP_PROGRAM);
		repeat (26) @(posedge clk);
		rd_st(32'h0d, 32'h01);
		op(OP_HW_RESET);
		rd_st(32'h31, 32'h0);
		chk_byte(8'h21);
		pgm_chk(8'h21, 8'h00, OP_PROGRAM);
		give_verdict();
	end
endmodule
